// ### logic/siad_pkg.sv
// package for the smm/inbound/io address decoder: address windows, field
// layouts, request and answer carriers shared by decoder and bench.
// assumes 40-bit system addresses and seven downstream ports.
package siad_pkg;
  localparam int NPORT = 7;
  localparam int AW = 40;

  localparam logic [39:0] LEG_LO = 40'h00_000a_0000;
  localparam logic [39:0] LEG_HI = 40'h00_000b_ffff;
  localparam logic [39:0] BIOS_LO = 40'h00_000c_0000;
  localparam logic [39:0] BIOS_HI = 40'h00_000f_ffff;
  localparam logic [39:0] HSMM_LO = 40'h00_feda_0000;
  localparam logic [39:0] HSMM_HI = 40'h00_fedb_ffff;
  localparam logic [39:0] HUB_LO = 40'h00_fe00_0000;
  localparam logic [39:0] HUB_HI = 40'h00_febf_ffff;
  localparam logic [39:0] INTR_LO = 40'h00_fee0_0000;
  localparam logic [39:0] INTR_HI = 40'h00_feef_ffff;
  localparam logic [39:0] CFGWIN_SIZE = 40'h00_1000_0000;
  localparam logic [1:0] BIOS_ATTR_RW = 2'h3;

  localparam logic [15:0] VGA_A_LO = 16'h03b0;
  localparam logic [15:0] VGA_A_HI = 16'h03bb;
  localparam logic [15:0] VGA_B_LO = 16'h03c0;
  localparam logic [15:0] VGA_B_HI = 16'h03df;
  localparam logic [15:0] CFG_ADDR_IO = 16'h0cf8;
  localparam logic [15:0] CFG_DATA_IO = 16'h0cfc;
  localparam logic [15:0] VGA10_MASK = 16'h03ff;
  localparam logic [3:0] SEG_SHIFT = 4'hc;

  // register offsets (word aligned)
  localparam logic [11:0] OFS_SMMCTL = 12'h000;
  localparam logic [11:0] OFS_SMMTOP = 12'h004;
  localparam logic [11:0] OFS_SEGSZ = 12'h008;
  localparam logic [11:0] OFS_CFGBASE = 12'h00c;
  localparam logic [11:0] OFS_MISC = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_PORT0 = 12'h020;
  // ext_smm_control fields
  localparam int F_GLOBAL = 0;
  localparam int F_HIGH = 1;
  localparam int F_EXTSEG = 2;
  localparam int F_LOCK = 3;
  localparam int F_CLOSED = 4;
  localparam int F_OPEN = 5;
  // per-port word: io_enable, vga, isa, vga16, base seg[11:8], limit seg[15:12]
  localparam int P_IOE = 0;
  localparam int P_VGA = 1;
  localparam int P_ISA = 2;
  localparam int P_VGA16 = 3;
  localparam int P_BASE = 8;
  localparam int P_LIM = 12;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    SIAD_MAIN_MEM, SIAD_SMM_MEM, SIAD_PORT, SIAD_SB_LINK, SIAD_ABORT,
    SIAD_CFG, SIAD_PROC_INTR, SIAD_HUB_REG
  } siad_dest_t;

  typedef struct packed {
    logic [39:0] addr;
    logic is_io;
    logic is_write;
    logic is_code;
    logic is_wb;        // writeback_kind
    logic smm_qual;     // smm_qualifier
    logic inbound;
    logic [2:0] src;    // 0 = southbridge_link, 1..7 = port
    logic [2:0] nbytes; // io byte count minus one
    logic hub_valid;
  } siad_req_t;

  typedef struct packed {
    siad_dest_t dest;
    logic [2:0] port;
    logic [39:0] addr;
    logic coherent;
    logic no_snoop;
    logic err;
  } siad_rsp_t;
endpackage

// ### logic/siad_decoder.sv
// address-disposition decoder: one request per valid, answer one cycle later.
// assumes requests arrive on ref_clk from logic in the same domain, registers over apb.
// Summary of operation
// - inbound hits enabled smm: abort, flag some
// - legacy window to smm only if granted
// - extended range disabled goes to plain memory
// - extended enabled: grant or writeback else abort
// - high smm remaps to legacy when permitted
// - vga needs exactly one enabled port
// - inbound targeting its own port aborts
// - inbound smm hits never snoop processor bus
// - inbound vga window: abort unless vga enabled
// - inbound bios segments need attribute eleven
// - inbound extended range: memory or abort
// - inbound config and hub registers abort
// - inbound high smm aborts with flag
// - inbound interrupt writes go to processors
// - io decodes bits fifteen to zero, wraps
// - after reset all io to southbridge
// - io space is sixteen 4kb segments
// - vga io ranges need every byte inside
// - cf8 dword/cfc with enable bit are config
// - isa alias upper 768 bytes to southbridge
// - io inside port base/limit goes there
// - io priority vga, config, isa, window
// - grant from enables, lock, qualifier, code/data
// - enables from control register, processors only
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module siad_decoder (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire siad_pkg::siad_req_t req,
  input wire logic [31:0] cfg_addr_port,
  input wire logic [1:0] bios_segment_attribute,
  output var siad_pkg::siad_rsp_t rsp,
  output logic rsp_valid
);
  import siad_pkg::*;

  logic [31:0] ext_smm_control_r;
  logic [31:0] ext_smm_top_r;
  logic [31:0] ext_segment_size_r;
  logic [31:0] cfg_window_base_r;
  logic [31:0] misc_r;
  logic invalid_smram_flag_r;
  logic [15:0] port_r [NPORT];

  logic wr_en, rd_en, unmapped;
  logic err_set;
  logic [2:0] pidx;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pidx = 3'(paddr[4:2]);
  always_comb begin
    unmapped = 1'b1;
    case (paddr)
      OFS_SMMCTL, OFS_SMMTOP, OFS_SEGSZ, OFS_CFGBASE, OFS_MISC, OFS_STATUS: unmapped = 1'b0;
      default: unmapped = !(paddr >= OFS_PORT0 && paddr < OFS_PORT0 + 12'h01c);
    endcase
  end

  // zero-wait slave: every access finishes in its first access cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
    end
  end

  logic acc;
  assign acc = psel && penable && pready;

  // one block per register; each takes a whole word, there are no byte strobes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_smm_control_r <= RST_ZERO;
    end else if (acc && wr_en && paddr == OFS_SMMCTL) begin
      ext_smm_control_r <= pwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_smm_top_r <= RST_ZERO;
    end else if (acc && wr_en && paddr == OFS_SMMTOP) begin
      ext_smm_top_r <= pwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_segment_size_r <= RST_ZERO;
    end else if (acc && wr_en && paddr == OFS_SEGSZ) begin
      ext_segment_size_r <= pwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_window_base_r <= RST_ZERO;
    end else if (acc && wr_en && paddr == OFS_CFGBASE) begin
      cfg_window_base_r <= pwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      misc_r <= RST_ZERO;
    end else if (acc && wr_en && paddr == OFS_MISC) begin
      misc_r <= pwdata;
    end
  end

  // port windows all cleared at reset so io falls to the southbridge
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          port_r[p] <= 16'h0000;
        end else if (acc && wr_en && paddr == OFS_PORT0 + 12'(4 * p)) begin
          port_r[p] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  // hardware set wins over a software write-one-to-clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      invalid_smram_flag_r <= 1'b0;
    end else if (err_set) begin
      invalid_smram_flag_r <= 1'b1;
    end else if (acc && wr_en && paddr == OFS_STATUS && pwdata[0]) begin
      invalid_smram_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= RST_ZERO;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_SMMCTL: prdata <= ext_smm_control_r;
        OFS_SMMTOP: prdata <= ext_smm_top_r;
        OFS_SEGSZ: prdata <= ext_segment_size_r;
        OFS_CFGBASE: prdata <= cfg_window_base_r;
        OFS_MISC: prdata <= misc_r;
        OFS_STATUS: prdata <= {31'h0000_0000, invalid_smram_flag_r};
        default: prdata <= unmapped ? RST_ZERO : {16'h0000, port_r[pidx - 3'h0]};
      endcase
    end
  end

  // ---------------- disposition ----------------
  logic g_en, h_en, t_en, d_lck, d_cls, d_ope;
  assign g_en = ext_smm_control_r[F_GLOBAL];
  assign h_en = ext_smm_control_r[F_HIGH];
  assign t_en = ext_smm_control_r[F_EXTSEG];
  assign d_lck = ext_smm_control_r[F_LOCK];
  assign d_cls = ext_smm_control_r[F_CLOSED];
  assign d_ope = ext_smm_control_r[F_OPEN] && !d_lck;

  // grant: legacy closed blocks data only; lock overrides open
  logic grant_leg, grant_ext;
  always_comb begin
    grant_ext = g_en && !req.inbound && (req.smm_qual || d_ope);
    grant_leg = grant_ext && (req.is_code || !d_cls || d_ope);
  end

  logic [39:0] ext_lo, ext_hi, cfg_lo;
  assign ext_hi = {8'h00, ext_smm_top_r};
  assign ext_lo = {8'h00, ext_smm_top_r - ext_segment_size_r};
  assign cfg_lo = {8'h00, cfg_window_base_r};

  // address windows, tested in the order of the disposition chain below
  logic in_leg, in_bios, in_ext, in_hsmm, in_cfgwin, in_hub, in_intr;
  assign in_leg = req.addr >= LEG_LO && req.addr <= LEG_HI;
  assign in_bios = req.addr >= BIOS_LO && req.addr <= BIOS_HI;
  assign in_ext = req.addr >= ext_lo && req.addr < ext_hi;
  assign in_hsmm = req.addr >= HSMM_LO && req.addr <= HSMM_HI;
  assign in_cfgwin = req.addr >= cfg_lo && req.addr < cfg_lo + CFGWIN_SIZE;
  assign in_hub = req.addr >= HUB_LO && req.addr <= HUB_HI;
  assign in_intr = req.addr >= INTR_LO && req.addr <= INTR_HI;

  // vga port: exactly one port with vga enable
  logic [3:0] vga_cnt;
  logic [2:0] vga_port;
  always_comb begin
    vga_cnt = 4'h0;
    vga_port = 3'h0;
    for (int p = 0; p < NPORT; p++) begin
      if (port_r[p][P_VGA]) begin
        vga_cnt = vga_cnt + 4'h1;
        vga_port = 3'(p + 1);
      end
    end
  end

  logic [15:0] io_a, io_last;
  always_comb begin
    io_a = {req.addr[15:3], req.addr[2:0]};
    io_last = io_a + {13'h0000, req.nbytes};
  end

  // per-port io matches; the priority pick below takes the lowest port first
  logic [NPORT-1:0] vga_hit, win_hit, isa_hit;
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_match
      logic [15:0] va, vl;
      assign va = port_r[p][P_VGA16] ? io_a : (io_a & VGA10_MASK);
      assign vl = port_r[p][P_VGA16] ? io_last : (io_last & VGA10_MASK);
      // a masked span that wraps past 3ffh ends below its start and never matches
      assign vga_hit[p] = port_r[p][P_IOE] && port_r[p][P_VGA] && vl >= va &&
        ((va >= VGA_A_LO && vl <= VGA_A_HI) || (va >= VGA_B_LO && vl <= VGA_B_HI));
      assign win_hit[p] = port_r[p][P_IOE] && io_a[15:SEG_SHIFT] >= port_r[p][P_BASE +: 4] &&
        io_a[15:SEG_SHIFT] <= port_r[p][P_LIM +: 4];
      assign isa_hit[p] = port_r[p][P_ISA] && io_a[9:8] != 2'b00;
    end
  endgenerate

  siad_rsp_t d;
  logic d_err;
  always_comb begin
    logic found;
    d = '{dest: SIAD_SB_LINK, port: 3'h0, addr: req.addr, coherent: 1'b0, no_snoop: 1'b0, err: 1'b0};
    d_err = 1'b0;
    found = 1'b0;
    if (req.is_io) begin
      d.addr = {24'h00_0000, io_a};
      for (int p = 0; p < NPORT; p++) begin
        if (!found && vga_hit[p]) begin
          found = 1'b1;
          d.dest = SIAD_PORT;
          d.port = 3'(p + 1);
        end
      end
      if (!found && !req.inbound && cfg_addr_port[31] &&
          ((io_a == CFG_ADDR_IO && req.nbytes == 3'h3) ||
           (io_a[15:2] == CFG_DATA_IO[15:2] && io_last <= CFG_DATA_IO + 16'h0003))) begin
        found = 1'b1;
        d.dest = SIAD_CFG;
      end
      for (int p = 0; p < NPORT; p++) begin
        if (!found && win_hit[p]) begin
          found = 1'b1;
          if (isa_hit[p]) begin
            d.dest = SIAD_SB_LINK;
          end else begin
            d.dest = SIAD_PORT;
            d.port = 3'(p + 1);
          end
        end
      end
    end else if (in_leg) begin
      if (req.inbound) begin
        if (vga_cnt == 4'h0) begin
          d.dest = SIAD_SB_LINK;
          d_err = 1'b1;
        end else if (vga_cnt == 4'h1) begin
          d.dest = SIAD_PORT;
          d.port = vga_port;
        end
        d.no_snoop = 1'b1;
      end else if (g_en && !h_en && grant_leg) begin
        d.dest = SIAD_SMM_MEM;
      end else if (vga_cnt == 4'h1) begin
        d.dest = SIAD_PORT;
        d.port = vga_port;
      end
    end else if (in_bios && req.inbound) begin
      d.dest = (bios_segment_attribute == BIOS_ATTR_RW) ? SIAD_MAIN_MEM : SIAD_ABORT;
    end else if (in_ext) begin
      d.dest = SIAD_MAIN_MEM;
      d.coherent = 1'b1;
      if (g_en && t_en) begin
        if (req.inbound) begin
          d.dest = SIAD_SB_LINK;
          d.coherent = 1'b0;
          d.no_snoop = 1'b1;
          d_err = 1'b1;
        end else if (grant_ext || req.is_wb) begin
          d.dest = SIAD_SMM_MEM;
        end else begin
          d.dest = SIAD_ABORT;
          d.coherent = 1'b0;
          d_err = 1'b1;
        end
      end
    end else if (in_hsmm) begin
      d.dest = SIAD_SB_LINK;
      if (req.inbound) begin
        d.no_snoop = 1'b1;
        d_err = 1'b1;
      end else if (g_en && h_en) begin
        if (grant_ext || req.is_wb) begin
          d.dest = SIAD_SMM_MEM;
          d.addr = req.addr - HSMM_LO + LEG_LO;
        end else begin
          d.dest = SIAD_ABORT;
          d_err = 1'b1;
        end
      end
    end else if (req.inbound && in_cfgwin) begin
      d.dest = SIAD_ABORT;
    end else if (in_hub) begin
      if (req.hub_valid) d.dest = req.inbound ? SIAD_ABORT : SIAD_HUB_REG;
    end else if (in_intr && req.inbound && req.is_write) begin
      d.dest = SIAD_PROC_INTR;
    end
    // inbound request that decodes back to its own port
    if (req.inbound && d.dest == SIAD_PORT && d.port == req.src) begin
      d.dest = SIAD_ABORT;
    end
    d.err = d_err;
  end

  assign err_set = req_valid && d_err;

  // one registered decision per accepted request
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp <= '{dest: SIAD_SB_LINK, port: 3'h0, addr: 40'h00_0000_0000, coherent: 1'b0, no_snoop: 1'b0, err: 1'b0};
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp <= d;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/siad_decoder_chk.sv
// checker for the decoder: request timing and routing relations at its ports.
// assumes it is bound to siad_decoder and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module siad_decoder_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic req_valid,
  input wire siad_pkg::siad_req_t req,
  input wire logic [31:0] cfg_addr_port,
  input wire siad_pkg::siad_rsp_t rsp,
  input wire logic rsp_valid
);
  import siad_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_inb_mem;
    req_valid && req.inbound && !req.is_io;
  endsequence
  sequence s_cfg_io;
    req_valid && req.is_io && !req.inbound && req.addr[15:0] == CFG_DATA_IO && req.nbytes <= 3'h3;
  endsequence
  rsp_follows_a: assert property (req_valid |=> rsp_valid)
    else $error("answer missing one cycle after request");
  rsp_cause_a: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  rsp_hold_a: assert property (!req_valid |=> $stable(rsp))
    else $error("answer changed without request");
  smm_proc_only_a: assert property (req_valid && req.inbound |=> rsp.dest != SIAD_SMM_MEM)
    else $error("inbound request reached smm memory");
  io_wrap_a: assert property (req_valid && req.is_io |=> rsp.addr[39:16] == 24'h00_0000)
    else $error("io address above bit 15 forwarded");
  intr_write_a: assert property (s_inb_mem ##0 req.is_write && req.addr inside {[INTR_LO:INTR_HI]}
    |=> rsp.dest == SIAD_PROC_INTR) else $error("inbound interrupt write misrouted");
  intr_other_a: assert property (s_inb_mem ##0 !req.is_write && req.addr inside {[INTR_LO:INTR_HI]}
    |=> rsp.dest == SIAD_SB_LINK) else $error("inbound interrupt read misrouted");
  high_smm_in_a: assert property (s_inb_mem ##0 req.addr inside {[HSMM_LO:HSMM_HI]}
    |=> rsp.err && rsp.dest == SIAD_SB_LINK) else $error("inbound high smm not aborted");
  cfg_io_a: assert property (s_cfg_io ##0 cfg_addr_port[31] |=> rsp.dest == SIAD_CFG)
    else $error("config data access not decoded");
  self_port_a: assert property (req_valid && req.inbound
    |=> !(rsp.dest == SIAD_PORT && rsp.port == $past(req.src))) else $error("inbound sent back to its own port");
  err_abort_a: assert property (rsp_valid && rsp.err |-> rsp.dest inside {SIAD_ABORT, SIAD_SB_LINK})
    else $error("flagged access was forwarded");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("slave error outside a bus answer");
endmodule
`default_nettype wire

// ### bench/siad_req_agent.sv
// request source model standing for the processor and io agents.
// assumes ref_clk is shared with the decoder; one request per issue call.
`timescale 1ns/1ps
`default_nettype none
module siad_req_agent (
  input wire logic ref_clk,
  input wire siad_pkg::siad_rsp_t rsp,
  input wire logic rsp_valid,
  output var siad_pkg::siad_req_t req,
  output var logic req_valid
);
  import siad_pkg::*;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  task automatic issue(input siad_req_t r, output siad_rsp_t o);
    int k;
    k = 0;
    @(posedge ref_clk);
    req <= r;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    // idle lines show the inverse, so a stale value is never mistaken for a request
    req <= ~r;
    // the answer is taken at the edge where rsp_valid is sampled high
    do begin
      @(posedge ref_clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 8);
    if (rsp_valid === 1'b1) begin
      o = rsp;
    end else begin
      o = 'x;
    end
  endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the address-disposition decoder.
// assumes the request agent model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import siad_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_valid;
  siad_req_t req;
  logic [31:0] cfg_addr_port = 32'h0000_0000;
  logic [1:0] attr = 2'h0;
  siad_rsp_t rsp;
  logic rsp_valid;
  siad_rsp_t lr;
  logic [31:0] q;
  logic se;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  siad_decoder u_siad_decoder (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .cfg_addr_port(cfg_addr_port), .bios_segment_attribute(attr),
    .rsp(rsp), .rsp_valid(rsp_valid));
  siad_req_agent u_siad_req_agent (.ref_clk(ref_clk), .rsp(rsp), .rsp_valid(rsp_valid), .req(req),
    .req_valid(req_valid));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(pready, 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // flags: io, write, code, writeback, qualifier, inbound, hub-valid; inbound comes from port 1
  task automatic go(input logic [39:0] a, input logic [6:0] f, input logic [2:0] n, input siad_dest_t d,
    input logic e);
    u_siad_req_agent.issue({a, f[6:1], f[1] ? 3'h1 : 3'h0, n, f[0]}, lr);
    chk(lr.dest, d);
    chk(lr.err, e);
  endtask
  task automatic t_io();
    go(16'h1004, 7'h40, 3'h3, SIAD_SB_LINK, 1'b0);
    apb(1'b1, OFS_SMMCTL, 32'h0000_0000);
    chk({se, q}, 33'h0_0000_0000);
    apb(1'b0, 12'hffc, 32'h0000_0000);
    chk({se, q}, 33'h1_0000_0000);
    apb(1'b1, OFS_PORT0, 32'h0000_2101);
    go(16'h1004, 7'h40, 3'h3, SIAD_PORT, 1'b0);
    chk(lr.port, 3'h1);
    go(16'h2ffc, 7'h40, 3'h3, SIAD_PORT, 1'b0);
    go(16'h3000, 7'h40, 3'h0, SIAD_SB_LINK, 1'b0);
    go(20'h1_0000, 7'h40, 3'h2, SIAD_SB_LINK, 1'b0);
    chk(lr.addr, 40'h0);
    go(16'h1004, 7'h42, 3'h0, SIAD_ABORT, 1'b0);
    apb(1'b1, OFS_PORT0, 32'h0000_2105);
    go(16'h1100, 7'h40, 3'h0, SIAD_SB_LINK, 1'b0);
    go(16'h14ff, 7'h40, 3'h0, SIAD_PORT, 1'b0);
    apb(1'b1, OFS_PORT0, 32'h0000_2107);
    go(16'h13b0, 7'h40, 3'h0, SIAD_PORT, 1'b0);
    go(16'h13bb, 7'h40, 3'h1, SIAD_SB_LINK, 1'b0);
    go(16'h13dc, 7'h40, 3'h3, SIAD_PORT, 1'b0);
    apb(1'b1, OFS_PORT0, 32'h0000_210f);
    go(16'h13b0, 7'h40, 3'h0, SIAD_SB_LINK, 1'b0);
    go(16'h03b0, 7'h40, 3'h0, SIAD_PORT, 1'b0);
    cfg_addr_port <= 32'h8000_0000;
    go(16'h0cf8, 7'h40, 3'h3, SIAD_CFG, 1'b0);
    go(16'h0cfc, 7'h40, 3'h0, SIAD_CFG, 1'b0);
    go(16'h0cf8, 7'h40, 3'h1, SIAD_SB_LINK, 1'b0);
    cfg_addr_port <= 32'h0000_0000;
    go(16'h0cf8, 7'h40, 3'h3, SIAD_SB_LINK, 1'b0);
    $display("io test done");
  endtask
  task automatic t_smm();
    go(20'ha_0000, 7'h04, 3'h0, SIAD_PORT, 1'b0);
    apb(1'b1, 12'h024, 32'h0000_0003);
    go(20'ha_0000, 7'h04, 3'h0, SIAD_SB_LINK, 1'b0);
    apb(1'b1, OFS_SMMTOP, 32'h0800_0000);
    apb(1'b1, OFS_SEGSZ, 32'h0010_0000);
    apb(1'b1, OFS_SMMCTL, 32'h0000_0001);
    go(20'ha_0000, 7'h04, 3'h0, SIAD_SMM_MEM, 1'b0);
    go(20'ha_0000, 7'h00, 3'h0, SIAD_SB_LINK, 1'b0);
    go(28'h7f0_0000, 7'h00, 3'h0, SIAD_MAIN_MEM, 1'b0);
    go(28'h7f0_0000, 7'h02, 3'h0, SIAD_MAIN_MEM, 1'b0);
    apb(1'b1, OFS_SMMCTL, 32'h0000_0005);
    go(28'h7f0_0000, 7'h00, 3'h0, SIAD_ABORT, 1'b1);
    go(28'h7f0_0000, 7'h08, 3'h0, SIAD_SMM_MEM, 1'b0);
    go(28'h7f0_0000, 7'h04, 3'h0, SIAD_SMM_MEM, 1'b0);
    go(28'h7f0_0000, 7'h02, 3'h0, SIAD_SB_LINK, 1'b1);
    chk(lr.no_snoop, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q[0], 1'b1);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q[0], 1'b0);
    apb(1'b1, OFS_SMMCTL, 32'h0000_0003);
    go(32'hfeda_0010, 7'h04, 3'h0, SIAD_SMM_MEM, 1'b0);
    chk(lr.addr, 40'h000a_0010);
    go(32'hfeda_0010, 7'h00, 3'h0, SIAD_ABORT, 1'b1);
    go(32'hfeda_0010, 7'h02, 3'h0, SIAD_SB_LINK, 1'b1);
    apb(1'b1, OFS_SMMCTL, 32'h0000_0001);
    go(32'hfeda_0010, 7'h04, 3'h0, SIAD_SB_LINK, 1'b0);
    $display("smm test done");
  endtask
  task automatic t_inb();
    attr <= BIOS_ATTR_RW;
    go(20'hc_0000, 7'h02, 3'h0, SIAD_MAIN_MEM, 1'b0);
    chk(lr.coherent, 1'b0);
    go(32'hfee0_0000, 7'h22, 3'h0, SIAD_PROC_INTR, 1'b0);
    go(32'hfee0_0000, 7'h02, 3'h0, SIAD_SB_LINK, 1'b0);
    go(32'hfe00_0000, 7'h03, 3'h0, SIAD_ABORT, 1'b0);
    go(32'hfe00_0000, 7'h02, 3'h0, SIAD_SB_LINK, 1'b0);
    apb(1'b1, OFS_CFGBASE, 32'h8000_0000);
    go(32'h8fff_fffc, 7'h02, 3'h0, SIAD_ABORT, 1'b0);
    go(20'ha_0000, 7'h02, 3'h0, SIAD_SB_LINK, 1'b0);
    apb(1'b1, 12'h024, 32'h0000_0000);
    go(20'ha_0000, 7'h02, 3'h0, SIAD_ABORT, 1'b0);
    apb(1'b1, OFS_PORT0, 32'h0000_0000);
    go(20'ha_0000, 7'h02, 3'h0, SIAD_SB_LINK, 1'b1);
    chk(lr.no_snoop, 1'b1);
    $display("inbound test done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    t_io();
    t_smm();
    t_inb();
    stop_test();
  end
endmodule
bind siad_decoder siad_decoder_chk u_siad_decoder_chk (.ref_clk(ref_clk), .resetn(resetn), .pready(pready),
  .pslverr(pslverr), .req_valid(req_valid), .req(req), .cfg_addr_port(cfg_addr_port), .rsp(rsp),
  .rsp_valid(rsp_valid));
`default_nettype wire
